// ### hw/vit_coproc_port.sv
// Control, status, timing and shared bank lockout of the decoder coprocessor.
`timescale 1ns/10ps
module vit_coproc_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core coprocessor moves
  input wire vit_coproc_pkg::coreMove_s coreMove,
  output logic [15:0] readData,
  output logic readValid,
  // Flag and interrupts
  output logic busyFlag,
  output logic doneInterrupt,
  output logic costOverflowInterrupt,
  input wire logic [1:0] statusClear,
  input wire logic interruptReturn,
  // Shared bank, core side
  input wire logic bankWr,
  input wire logic [vit_coproc_pkg::BANK_AW-1:0] bankAddr,
  input wire logic [15:0] bankWdata,
  output logic [15:0] bankRdata,
  // Decoder datapath side
  input wire logic traceWr,
  input wire logic [vit_coproc_pkg::BANK_AW-1:0] traceAddr,
  input wire logic [15:0] traceWdata,
  input wire logic costLoad,
  input wire logic [7:0] costLoadHigh,
  input wire logic [7:0] decodedIn,
  input wire logic [vit_coproc_pkg::INDEX_W-1:0] minIndexIn
);

  // ********************************************************
  // Declarations
  // ********************************************************
  vit_coproc_pkg::state_e state_reg;
  vit_coproc_pkg::cmdKind_e kind_reg;
  vit_coproc_pkg::cmdKind_e kind_next;
  vit_coproc_pkg::decoderCtrl_s ctrl_reg;
  logic [15:0] addr_reg;
  logic [10:0] cnt_reg;
  logic [10:0] cycles;
  logic [vit_coproc_pkg::RETRACE_W-1:0] retraceLen_reg;
  logic [vit_coproc_pkg::RX_SYM_W-1:0] inphase_reg;
  logic [vit_coproc_pkg::RX_SYM_W-1:0] quad_reg;
  logic [vit_coproc_pkg::INDEX_W-1:0] minIndex_reg;
  logic [15:0] decoded_reg;
  logic [15:0] readMux;
  logic [15:0] rdStage_reg;
  logic rdPend_reg;
  logic [15:0] readData_reg;
  logic readValid_reg;
  logic done_reg;
  logic ovf_reg;
  logic ovfPend_reg;
  logic instrAccept;
  logic resetCmd;
  logic startCmd;
  logic dataWrOk;
  logic dataRdOk;
  logic finish;
  logic ovfDetect;
  logic ovfRaise;
  logic doneSet;
  logic [12:0] winSize;
  logic traceInWindow;
  logic memWe;
  logic [vit_coproc_pkg::BANK_AW-1:0] memWaddr;
  logic [vit_coproc_pkg::BANK_AW-1:0] memRaddr;
  logic [15:0] memWdata;

  function automatic logic isCostHigh(input logic [15:0] a);
    isCostHigh = (a <= vit_coproc_pkg::OFS_NS_LAST) && !a[0];
  endfunction

  // ********************************************************
  // Move decode
  // ********************************************************
  assign busyFlag = (state_reg == vit_coproc_pkg::ST_RUN);
  assign instrAccept = coreMove.instrWr && !busyFlag;
  assign resetCmd = instrAccept && (coreMove.wdata == vit_coproc_pkg::CMD_RESET);
  assign startCmd = instrAccept && ((coreMove.wdata == vit_coproc_pkg::CMD_EQ_UPDATE)
    || (coreMove.wdata == vit_coproc_pkg::CMD_CONV_UPDATE)
    || (coreMove.wdata == vit_coproc_pkg::CMD_RETRACE));
  assign dataWrOk = coreMove.dataWr && !busyFlag;
  assign dataRdOk = coreMove.dataRd && !busyFlag;
  assign finish = busyFlag && (cnt_reg == 11'h001);

  always_comb begin
    kind_next = vit_coproc_pkg::KIND_RETRACE;
    if (coreMove.wdata == vit_coproc_pkg::CMD_EQ_UPDATE) begin
      kind_next = vit_coproc_pkg::KIND_EQ;
    end else if (coreMove.wdata == vit_coproc_pkg::CMD_CONV_UPDATE) begin
      kind_next = vit_coproc_pkg::KIND_CONV;
    end
  end

  cmd_cycle_calc u_calc (
    .kind(kind_next),
    .ctrl(ctrl_reg),
    .retraceLen(retraceLen_reg),
    .cycles(cycles)
  );

  // ********************************************************
  // Command sequencer
  // ********************************************************
  // Busy spans write to data ready.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= vit_coproc_pkg::ST_IDLE;
      cnt_reg <= 11'h000;
    end else begin
      unique case (state_reg)
        vit_coproc_pkg::ST_IDLE: begin
          if (startCmd) begin
            state_reg <= vit_coproc_pkg::ST_RUN;
            cnt_reg <= cycles;
          end
        end
        vit_coproc_pkg::ST_RUN: begin
          cnt_reg <= cnt_reg - 11'h001;
          if (cnt_reg == 11'h001) begin
            state_reg <= vit_coproc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      kind_reg <= vit_coproc_pkg::KIND_EQ;
    end else if (startCmd) begin
      kind_reg <= kind_next;
    end
  end

  // ********************************************************
  // Register file
  // ********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_reg <= 16'h0000;
    end else if (coreMove.addrWr) begin
      addr_reg <= coreMove.wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '0;
    end else if (resetCmd) begin
      ctrl_reg <= '0;
    end else if (dataWrOk && (addr_reg == vit_coproc_pkg::OFS_CONTROL)) begin
      ctrl_reg.hardSoft <= coreMove.wdata[vit_coproc_pkg::CTRL_HS_POS];
      ctrl_reg.cl <= coreMove.wdata[vit_coproc_pkg::CTRL_CL_LSB +: vit_coproc_pkg::CL_W];
    end
  end

  // Length drops by one after a retrace.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      retraceLen_reg <= vit_coproc_pkg::RETRACE_LEN_RST;
    end else if (resetCmd) begin
      retraceLen_reg <= vit_coproc_pkg::RETRACE_LEN_RST;
    end else if (finish && (kind_reg == vit_coproc_pkg::KIND_RETRACE)) begin
      retraceLen_reg <= retraceLen_reg - 6'h01;
    end else if (dataWrOk && (addr_reg == vit_coproc_pkg::OFS_RETRACE_LEN)) begin
      retraceLen_reg <= coreMove.wdata[vit_coproc_pkg::RETRACE_W-1:0];
    end
  end

  // Received sample words keep low ten bits.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inphase_reg <= '0;
      quad_reg <= '0;
    end else if (resetCmd) begin
      inphase_reg <= '0;
      quad_reg <= '0;
    end else if (dataWrOk && (addr_reg == vit_coproc_pkg::OFS_INPHASE)) begin
      inphase_reg <= coreMove.wdata[vit_coproc_pkg::RX_SYM_W-1:0];
    end else if (dataWrOk && (addr_reg == vit_coproc_pkg::OFS_QUAD)) begin
      quad_reg <= coreMove.wdata[vit_coproc_pkg::RX_SYM_W-1:0];
    end
  end

  // Updates load the minimum cost index.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      minIndex_reg <= '0;
    end else if (resetCmd) begin
      minIndex_reg <= '0;
    end else if (finish && (kind_reg != vit_coproc_pkg::KIND_RETRACE)) begin
      minIndex_reg <= minIndexIn;
    end else if (dataWrOk && (addr_reg == vit_coproc_pkg::OFS_MIN_INDEX)) begin
      minIndex_reg <= coreMove.wdata[vit_coproc_pkg::INDEX_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      decoded_reg <= 16'h0000;
    end else if (resetCmd) begin
      decoded_reg <= 16'h0000;
    end else if (finish && ctrl_reg.hardSoft) begin
      decoded_reg <= {decodedIn[7], 15'h0000};
    end else if (finish) begin
      decoded_reg <= {decodedIn, 8'h00};
    end
  end

  // Reserved and unmapped words read as zero.
  always_comb begin
    readMux = 16'h0000;
    case (addr_reg)
      vit_coproc_pkg::OFS_CONTROL: begin
        readMux[vit_coproc_pkg::CTRL_HS_POS] = ctrl_reg.hardSoft;
        readMux[vit_coproc_pkg::CTRL_CL_LSB +: vit_coproc_pkg::CL_W] = ctrl_reg.cl;
      end
      vit_coproc_pkg::OFS_RETRACE_LEN: readMux = {10'h000, retraceLen_reg};
      vit_coproc_pkg::OFS_DECODED: readMux = decoded_reg;
      vit_coproc_pkg::OFS_INPHASE: readMux = {6'h00, inphase_reg};
      vit_coproc_pkg::OFS_QUAD: readMux = {6'h00, quad_reg};
      vit_coproc_pkg::OFS_MIN_INDEX: readMux = {8'h00, minIndex_reg};
      default: readMux = 16'h0000;
    endcase
  end

  // ********************************************************
  // Two-cycle read move
  // ********************************************************
  // Read data arrive two cycles after the move.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdPend_reg <= 1'b0;
      rdStage_reg <= 16'h0000;
      readValid_reg <= 1'b0;
      readData_reg <= 16'h0000;
    end else begin
      rdPend_reg <= dataRdOk;
      if (dataRdOk) begin
        rdStage_reg <= readMux;
      end
      readValid_reg <= rdPend_reg;
      if (rdPend_reg) begin
        readData_reg <= rdStage_reg;
      end
    end
  end

  assign readData = readData_reg;
  assign readValid = readValid_reg;

  // ********************************************************
  // Interrupts
  // ********************************************************
  // Done rises three cycles before busy falls.
  assign doneSet = busyFlag && (cnt_reg == (vit_coproc_pkg::DONE_LEAD_CYC + 11'h001));

  // Set wins over a same-cycle clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (doneSet) begin
      done_reg <= 1'b1;
    end else if (statusClear[0] || interruptReturn) begin
      done_reg <= 1'b0;
    end
  end

  // Overflow is held until the command ends.
  assign ovfDetect = (costLoad && (costLoadHigh == vit_coproc_pkg::OVF_PATTERN))
    || (dataWrOk && isCostHigh(addr_reg)
    && (coreMove.wdata[7:0] == vit_coproc_pkg::OVF_PATTERN));
  assign ovfRaise = (finish && (ovfPend_reg || ovfDetect)) || (!busyFlag && ovfDetect);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovfPend_reg <= 1'b0;
    end else if (finish || resetCmd) begin
      ovfPend_reg <= 1'b0;
    end else if (busyFlag && ovfDetect) begin
      ovfPend_reg <= 1'b1;
    end
  end

  // Write-one or return clears; set wins.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else if (ovfRaise) begin
      ovf_reg <= 1'b1;
    end else if (statusClear[1] || interruptReturn) begin
      ovf_reg <= 1'b0;
    end
  end

  assign doneInterrupt = done_reg;
  assign costOverflowInterrupt = ovf_reg;

  // ********************************************************
  // Shared retrace bank
  // ********************************************************
  // Window is two to the length field plus five or three.
  // Wide enough for the largest soft window, which is bigger than the bank itself.
  assign winSize = 13'h0001 << ({1'b0, ctrl_reg.cl}
    + (ctrl_reg.hardSoft ? vit_coproc_pkg::HARD_WIN_EXP : vit_coproc_pkg::SOFT_WIN_EXP));
  assign traceInWindow = ({3'b000, traceAddr} <= winSize);

  // While busy the coprocessor owns the bank.
  // Core reads in that time see the retrace address, which is the corruption.
  assign memWe = busyFlag ? (traceWr && traceInWindow) : bankWr;
  assign memWaddr = busyFlag ? traceAddr : bankAddr;
  assign memRaddr = busyFlag ? traceAddr : bankAddr;
  assign memWdata = busyFlag ? traceWdata : bankWdata;

  retrace_bank_ram u_bank (
    .mclk(mclk),
    .we(memWe),
    .waddr(memWaddr),
    .wdata(memWdata),
    .raddr(memRaddr),
    .rdata(bankRdata)
  );

  // ********************************************************
  // Checks
  // ********************************************************
  AST_BUSY_LOAD: assert property (@(posedge mclk) disable iff (rst)
    startCmd |=> busyFlag && (cnt_reg == $past(cycles)))
    else $error("Busy or count wrong after command write.");

  AST_DONE_LEAD: assert property (@(posedge mclk) disable iff (rst)
    $rose(doneInterrupt) |-> busyFlag [*3] ##1 !busyFlag)
    else $error("Done interrupt not three cycles ahead of busy fall.");

  AST_INSTR_IGNORED: assert property (@(posedge mclk) disable iff (rst)
    busyFlag && coreMove.instrWr && !finish |=> busyFlag && $stable(ctrl_reg))
    else $error("Instruction write acted while busy.");

  AST_READ_TWO: assert property (@(posedge mclk) disable iff (rst)
    readValid |-> $past(dataRdOk, 2) && (readData == $past(readMux, 2)))
    else $error("Read data not two cycles after an accepted read.");

  AST_OVF_AFTER: assert property (@(posedge mclk) disable iff (rst)
    $rose(costOverflowInterrupt) |-> !busyFlag)
    else $error("Overflow interrupt raised during a command.");

  AST_OVF_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (statusClear[1] || interruptReturn) && !ovfRaise |=> !costOverflowInterrupt)
    else $error("Overflow interrupt not cleared.");

  AST_DONE_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    interruptReturn && !doneSet |=> !doneInterrupt)
    else $error("Done interrupt not cleared by return.");

  AST_BANK_LOCK: assert property (@(posedge mclk) disable iff (rst)
    busyFlag && bankWr && !traceWr |-> !memWe)
    else $error("Core write reached the bank while busy.");

  AST_RETRACE_DEC: assert property (@(posedge mclk) disable iff (rst)
    finish && (kind_reg == vit_coproc_pkg::KIND_RETRACE)
    |=> retraceLen_reg == 6'($past(retraceLen_reg) - 6'h01))
    else $error("Retrace length not decremented.");

  AST_RX_HOLD: assert property (@(posedge mclk) disable iff (rst)
    dataWrOk && (addr_reg == vit_coproc_pkg::OFS_INPHASE) && !resetCmd
    |=> inphase_reg == $past(coreMove.wdata[9:0]))
    else $error("In-phase sample not stored.");

  AST_SYMBOL: assert property (@(posedge mclk) disable iff (rst)
    finish && ctrl_reg.hardSoft |=> decoded_reg == {$past(decodedIn[7]), 15'h0000})
    else $error("Hard decoded symbol misplaced.");

  AST_RESET_CMD: assert property (@(posedge mclk) disable iff (rst)
    resetCmd |=> !busyFlag && (retraceLen_reg == vit_coproc_pkg::RETRACE_LEN_RST))
    else $error("Reset command did not act at once.");

endmodule

// ### hw/vit_coproc_pkg.sv
// Constants, encodings and carrier types for the decoder coprocessor port.
// Function
// - Hold 10-bit in-phase and quadrature samples
// - Busy rises on update or retrace command
// - While busy ignore data reads, instruction writes
// - Two interrupts, maskable, cleared by interrupt return; this port has no mask, the outputs follow the flags
// - Done interrupt leads busy fall by three
// - Cost overflow raised after current command ends
// - Overflow cleared by write-one or return
// - Busy locks core writes to shared bank
// - Retrace storage window sized by mode, length
// - Moves take two cycles; reset instantaneous
// - Count from instruction write to data ready
// - Soft equalizer update cycle formula
// - Hard equalizer update cycle formula
// - Soft convolutional update cycle formula
// - Hard convolutional update cycle formula
// - Retrace time from length; length decrements
// - Decoded symbol placed in upper byte
// - Updates load minimum cost state index
package vit_coproc_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [15:0] OFS_CONTROL = 16'h0401;
  localparam logic [15:0] OFS_RETRACE_LEN = 16'h0402;
  localparam logic [15:0] OFS_DECODED = 16'h0409;
  localparam logic [15:0] OFS_INPHASE = 16'h040A;
  localparam logic [15:0] OFS_QUAD = 16'h040B;
  localparam logic [15:0] OFS_MIN_INDEX = 16'h040D;
  localparam logic [15:0] OFS_NS_LAST = 16'h007F;
  localparam logic [15:0] BANK_BASE = 16'h0C00;

  // ********************************************************
  // Fields and reset values
  // ********************************************************
  localparam int RX_SYM_W = 10;
  localparam int RETRACE_W = 6;
  localparam int INDEX_W = 8;
  localparam int CL_W = 3;
  localparam int CTRL_HS_POS = 1;
  localparam int CTRL_CL_LSB = 2;
  localparam int BANK_AW = 10;
  localparam int BANK_DEPTH = 1024;
  localparam logic [RETRACE_W-1:0] RETRACE_LEN_RST = 6'h01;
  localparam logic [7:0] OVF_PATTERN = 8'hFF;
  localparam logic [3:0] SOFT_WIN_EXP = 4'h5;
  localparam logic [3:0] HARD_WIN_EXP = 4'h3;

  // ********************************************************
  // Commands
  // ********************************************************
  localparam logic [15:0] CMD_RESET = 16'h0001;
  localparam logic [15:0] CMD_EQ_UPDATE = 16'h0002;
  localparam logic [15:0] CMD_CONV_UPDATE = 16'h0003;
  localparam logic [15:0] CMD_RETRACE = 16'h0004;

  // ********************************************************
  // Cycle counts
  // ********************************************************
  localparam logic [10:0] EQ_BASE_CYC = 11'h00F;
  localparam logic [10:0] CONV_BASE_CYC = 11'h00E;
  localparam logic [10:0] EQ_SUB_CYC = 11'h004;
  localparam logic [10:0] CONV_SUB_CYC = 11'h003;
  localparam logic [10:0] RETRACE_BASE_CYC = 11'h008;
  localparam logic [10:0] DONE_LEAD_CYC = 11'h003;
  localparam int MOVE_CYC = 2;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} state_e;
  typedef enum logic [2:0] {
    KIND_EQ = 3'b001,
    KIND_CONV = 3'b010,
    KIND_RETRACE = 3'b100
  } cmdKind_e;

  typedef struct packed {
    logic addrWr;
    logic dataWr;
    logic dataRd;
    logic instrWr;
    logic [15:0] wdata;
  } coreMove_s;

  typedef struct packed {
    logic [CL_W-1:0] cl;
    logic hardSoft;
  } decoderCtrl_s;

endpackage

// ### hw/cmd_cycle_calc.sv
// Cycle count of each coprocessor command from mode, length field and retrace length.
`timescale 1ns/10ps
module cmd_cycle_calc (
  // Command and settings
  input wire vit_coproc_pkg::cmdKind_e kind,
  input wire vit_coproc_pkg::decoderCtrl_s ctrl,
  input wire logic [vit_coproc_pkg::RETRACE_W-1:0] retraceLen,
  // Result
  output logic [10:0] cycles
);

  logic [10:0] pow2;
  logic [10:0] extra;
  logic [10:0] base;
  logic [10:0] sub;
  logic [10:0] posPart;
  logic [10:0] negPart;

  // Formula terms shared by all four update cases.
  always_comb begin
    pow2 = 11'h001 << ({1'b0, ctrl.cl} + 4'h2);
    if (!ctrl.hardSoft) begin
      extra = 11'h001 << ctrl.cl;
    end else if (ctrl.cl >= 3'h3) begin
      extra = 11'h001 << (ctrl.cl - 3'h3);
    end else begin
      extra = 11'h001;
    end
    base = vit_coproc_pkg::CONV_BASE_CYC;
    sub = vit_coproc_pkg::CONV_SUB_CYC;
    if (kind == vit_coproc_pkg::KIND_EQ) begin
      base = vit_coproc_pkg::EQ_BASE_CYC;
      sub = vit_coproc_pkg::EQ_SUB_CYC;
    end
    posPart = {5'h00, retraceLen} + extra;
    negPart = pow2 + sub;
  end

  always_comb begin
    if (kind == vit_coproc_pkg::KIND_RETRACE) begin
      cycles = vit_coproc_pkg::RETRACE_BASE_CYC + {5'h00, retraceLen};
    end else if (posPart > negPart) begin
      cycles = base + pow2 + (posPart - negPart);
    end else begin
      cycles = base + pow2;
    end
  end

endmodule

// ### hw/retrace_bank_ram.sv
// Shared 1 Kword retrace bank with a registered read port.
`timescale 1ns/10ps
module retrace_bank_ram (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [vit_coproc_pkg::BANK_AW-1:0] waddr,
  input wire logic [15:0] wdata,
  // Read port
  input wire logic [vit_coproc_pkg::BANK_AW-1:0] raddr,
  output logic [15:0] rdata
);

  logic [15:0] mem [vit_coproc_pkg::BANK_DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Contents carry no reset; only the read register matters to callers.
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end

endmodule

// ### tb/core_model.sv
// Core side model that issues coprocessor data moves and instructions.
`timescale 1ns/10ps
module core_model (
  // Clock
  input wire logic mclk,
  // Moves and answer
  output vit_coproc_pkg::coreMove_s coreMove,
  input wire logic [15:0] readData,
  input wire logic readValid
);
  initial coreMove = '0;

  // two cycle move
  // The strobe is dropped for one cycle so back-to-back moves stay distinct.
  task automatic mv(input logic [3:0] k, input logic [15:0] d);
    @(posedge mclk) coreMove <= {k, d};
    @(posedge mclk) coreMove <= '0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    mv(4'h8, a);
    mv(4'h2, 16'h0000);
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (readValid === 1'b1 && !ok) begin
        ok = 1'b1;
        q = readData;
      end
    end
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the decoder coprocessor port.
`timescale 1ns/10ps
module tb;
  logic mclk, rst, readValid, busyFlag, doneInterrupt, costOverflowInterrupt;
  logic interruptReturn, bankWr, costLoad, ok, traceWr;
  logic [1:0] statusClear;
  logic [9:0] bankAddr, traceAddr;
  logic [15:0] readData, bankWdata, bankRdata, q, traceWdata;
  logic [7:0] costLoadHigh;
  vit_coproc_pkg::coreMove_s coreMove;
  int error_cnt = 0;
  int check_count = 0;
  int n, dn;
  // Command, hard, length field, retrace length, expected cycles.
  int rows[11][5] = '{'{2, 0, 0, 1, 19}, '{2, 0, 1, 12, 25}, '{2, 0, 4, 31, 79},
    '{2, 1, 1, 15, 27}, '{2, 1, 3, 38, 50}, '{3, 0, 0, 7, 19}, '{3, 0, 2, 19, 34},
    '{3, 1, 3, 38, 50}, '{3, 1, 4, 63, 78}, '{3, 1, 5, 63, 142}, '{4, 0, 0, 5, 13}};

  vit_coproc_port vit_coproc_port_inst (.mclk(mclk), .rst(rst), .coreMove(coreMove),
    .readData(readData), .readValid(readValid), .busyFlag(busyFlag),
    .doneInterrupt(doneInterrupt), .costOverflowInterrupt(costOverflowInterrupt),
    .statusClear(statusClear), .interruptReturn(interruptReturn), .bankWr(bankWr),
    .bankAddr(bankAddr), .bankWdata(bankWdata), .bankRdata(bankRdata), .traceWr(traceWr),
    .traceAddr(traceAddr), .traceWdata(traceWdata), .costLoad(costLoad),
    .costLoadHigh(costLoadHigh), .decodedIn(8'hA5), .minIndexIn(8'h3C));
  core_model core_model_inst (.mclk(mclk), .coreMove(coreMove), .readData(readData),
    .readValid(readValid));

  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [15:0] e);
    core_model_inst.rd(a, q, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(q, e);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    core_model_inst.mv(4'h8, a);
    core_model_inst.mv(4'h4, d);
  endtask

  // poll busy flag
  // Counts busy cycles and the position of the done rise, bounded.
  task automatic waitIdle;
    n = 0;
    dn = 0;
    #1;
    while (busyFlag === 1'b1 && n < 400) begin
      n++;
      if (doneInterrupt === 1'b1 && dn == 0) begin
        dn = n;
      end
      @(posedge mclk);
      #1;
    end
    if (n >= 400) begin
      error_cnt++;
      final_report;
    end
  endtask

  task automatic clr;
    @(posedge mclk) interruptReturn <= 1'b1;
    @(posedge mclk) interruptReturn <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    rst = 1'b1;
    statusClear = 2'b00;
    interruptReturn = 1'b0;
    bankWr = 1'b0;
    bankAddr = 10'h000;
    bankWdata = 16'h0000;
    traceWr = 1'b0;
    traceAddr = 10'h000;
    traceWdata = 16'h0000;
    costLoad = 1'b0;
    costLoadHigh = 8'h00;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdChk(16'h0402, 16'h0001);
    rdChk(16'h0410, 16'h0000);
    wr(16'h040A, 16'hFFFF);
    rdChk(16'h040A, 16'h03FF);
    wr(16'h040B, 16'h0155);
    rdChk(16'h040B, 16'h0155);
    for (int i = 0; i < 11; i++) begin
      wr(16'h0401, 16'(rows[i][1] * 2 + rows[i][2] * 4));
      wr(16'h0402, 16'(rows[i][3]));
      core_model_inst.mv(4'h1, 16'(rows[i][0]));
      waitIdle();
      chk(16'(n), 16'(rows[i][4]));
      chk(16'(dn), 16'(rows[i][4] - 2));
      rdChk(16'h0409, (rows[i][1] == 1) ? 16'h8000 : 16'hA500);
      clr();
    end
    rdChk(16'h0402, 16'h0004);
    rdChk(16'h040D, 16'h003C);
    @(posedge mclk) bankWr <= 1'b1;
    bankWdata <= 16'h1234;
    @(posedge mclk) bankWr <= 1'b0;
    core_model_inst.mv(4'h1, 16'h0004);
    @(posedge mclk) costLoad <= 1'b1;
    costLoadHigh <= 8'hFF;
    bankWr <= 1'b1;
    bankWdata <= 16'hBEEF;
    @(posedge mclk) costLoad <= 1'b0;
    bankWr <= 1'b0;
    traceWr <= 1'b1;
    traceAddr <= 10'h005;
    traceWdata <= 16'h5A5A;
    @(posedge mclk) traceWr <= 1'b0;
    wr(16'h040A, 16'h0011);
    core_model_inst.mv(4'h1, 16'h0001);
    chk({15'h0000, costOverflowInterrupt}, 16'h0000);
    waitIdle();
    chk({15'h0000, costOverflowInterrupt}, 16'h0001);
    @(posedge mclk) statusClear <= 2'b10;
    @(posedge mclk) statusClear <= 2'b00;
    #1;
    chk({14'h0000, doneInterrupt, costOverflowInterrupt}, 16'h0002);
    clr();
    #1;
    chk({15'h0000, doneInterrupt}, 16'h0000);
    chk(bankRdata, 16'h1234);
    @(posedge mclk) bankAddr <= 10'h005;
    @(posedge mclk);
    #1;
    chk(bankRdata, 16'h5A5A);
    rdChk(16'h040A, 16'h03FF);
    rdChk(16'h0402, 16'h0003);
    core_model_inst.mv(4'h1, 16'h0001);
    rdChk(16'h0402, 16'h0001);
    wr(16'h0010, 16'h00FF);
    #1;
    chk({15'h0000, costOverflowInterrupt}, 16'h0001);
    clr();
    #1;
    chk({15'h0000, costOverflowInterrupt}, 16'h0000);
    core_model_inst.mv(4'h1, 16'h0004);
    @(posedge mclk) rst <= 1'b1;
    #1;
    chk({12'h000, busyFlag, doneInterrupt, costOverflowInterrupt, readValid}, 16'h0000);
    @(posedge mclk) rst <= 1'b0;
    core_model_inst.mv(4'h1, 16'h0004);
    waitIdle();
    chk(16'(n), 16'h0009);
    @(posedge mclk) statusClear <= 2'b01;
    @(posedge mclk) statusClear <= 2'b00;
    #1;
    chk({15'h0000, doneInterrupt}, 16'h0000);
    final_report();
  end
endmodule
